// ### src/cmp_ctrl_regs.sv
// comparator control/status registers on the special-function-reg port
`timescale 1ns/1ns

// Summary of operation
// - comparator0 mode bits 1-0 give the response-time code to the core.
// - comparator0 mode bit 5 enables the rising-edge interrupt.
// - comparator0 mode bit 4 enables the falling-edge interrupt.
// - unused bits 7-6 and 3-2 read zero and ignore writes.
// - comparator1 control bit 7 enables comparator1; reset disabled.
// - control bit 6 is read-only and shows the synchronised result.
// - control bit 5 sets on a rising result edge and holds.
// - control bit 4 sets on a falling result edge and holds.
// - control bits 3-2 give the positive hysteresis code to the core.
// - control bits 1-0 give the negative hysteresis code to the core.
// - mux bits 5-4 pick the negative input pin.
// - mux bits 1-0 pick the positive input pin.
// - comparator1 mode bits 1-0 select response time, same codes.
// - comparator1 mode bits 5/4 enable edge interrupts; mode resets 10.
// - edge flags stay set until software writes zero.
// - a disabled comparator drives its pin output low.
module cmp_ctrl_regs (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_b,
  input  wire logic [7:0]             i_sfr_addr,
  input  wire logic                   i_sfr_wr,
  input  wire logic                   i_sfr_rd,
  input  wire logic [7:0]             i_sfr_wdata,
  output logic      [7:0]             o_sfr_rdata,
  input  wire logic                   i_cmp1_raw,
  input  wire logic                   i_cmp0_rise_flag,
  input  wire logic                   i_cmp0_fall_flag,
  output cmp_regs_pkg::resp_e         o_cmp0_response,
  output logic                        o_cmp0_irq,
  output cmp_regs_pkg::cmp_cfg_s      o_cmp1_cfg,
  output logic                        o_cmp1_pin_out,
  output logic                        o_cmp1_irq
);
  import cmp_regs_pkg::*;

  // stored register state
  logic   cmp0_rise_irq_en_q;
  logic   cmp0_fall_irq_en_q;
  resp_e  cmp0_response_sel_q;
  logic   cmp1_enable_q;
  logic   cmp1_rise_flag_q;
  logic   cmp1_fall_flag_q;
  field_t cmp1_pos_hyst_sel_q;
  field_t cmp1_neg_hyst_sel_q;
  field_t cmp1_neg_input_sel_q;
  field_t cmp1_pos_input_sel_q;
  logic   cmp1_rise_irq_en_q;
  logic   cmp1_fall_irq_en_q;
  resp_e  cmp1_response_sel_q;

  logic   cmp1_result;
  logic   cmp1_rise;
  logic   cmp1_fall;
  logic   wr_ctrl;
  logic   wr_mode1;
  logic   wr_mode0;
  logic   wr_mux;
  logic   cmp1_rise_flag_d;
  logic   cmp1_fall_flag_d;
  logic   [7:0] rdata_d;

  // mode registers share one layout: enables at 5/4, response at 1-0
  function automatic logic [7:0] mode_image(input logic rie,
                                            input logic fie,
                                            input resp_e resp);
    logic [7:0] img;
    img = 8'h00;
    img[MODE_RIE_BIT] = rie;
    img[MODE_FIE_BIT] = fie;
    img[MODE_RESP_LSB +: FIELD_W] = resp;
    return img;
  endfunction

  // raw analog output is asynchronous to the core clock
  cmp_sync u_cmp1_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_raw      (i_cmp1_raw),
    .o_level    (cmp1_result),
    .o_rise     (cmp1_rise),
    .o_fall     (cmp1_fall)
  );

  // address decode of write strobes
  assign wr_ctrl  = i_sfr_wr && (i_sfr_addr == CMP1_CTRL_ADDR);
  assign wr_mode1 = i_sfr_wr && (i_sfr_addr == CMP1_MODE_ADDR);
  assign wr_mode0 = i_sfr_wr && (i_sfr_addr == CMP0_MODE_ADDR);
  assign wr_mux   = i_sfr_wr && (i_sfr_addr == CMP1_MUX_ADDR);

  // comparator0 mode register; bits 7-6 and 3-2 have no storage
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmp0_rise_irq_en_q  <= CMP0_MODE_RST[MODE_RIE_BIT];
      cmp0_fall_irq_en_q  <= CMP0_MODE_RST[MODE_FIE_BIT];
      cmp0_response_sel_q <= resp_e'(CMP0_MODE_RST[MODE_RESP_LSB +: FIELD_W]);
    end else if (wr_mode0) begin
      cmp0_rise_irq_en_q  <= i_sfr_wdata[MODE_RIE_BIT];
      cmp0_fall_irq_en_q  <= i_sfr_wdata[MODE_FIE_BIT];
      cmp0_response_sel_q <= resp_e'(i_sfr_wdata[MODE_RESP_LSB +: FIELD_W]);
    end
  end

  // comparator1 mode register, resets to the mid-slow mode code
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmp1_rise_irq_en_q  <= CMP1_MODE_RST[MODE_RIE_BIT];
      cmp1_fall_irq_en_q  <= CMP1_MODE_RST[MODE_FIE_BIT];
      cmp1_response_sel_q <= resp_e'(CMP1_MODE_RST[MODE_RESP_LSB +: FIELD_W]);
    end else if (wr_mode1) begin
      cmp1_rise_irq_en_q  <= i_sfr_wdata[MODE_RIE_BIT];
      cmp1_fall_irq_en_q  <= i_sfr_wdata[MODE_FIE_BIT];
      cmp1_response_sel_q <= resp_e'(i_sfr_wdata[MODE_RESP_LSB +: FIELD_W]);
    end
  end

  // comparator1 control: enable and hysteresis; bit 6 is not stored
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmp1_enable_q       <= CMP1_CTRL_RST[CTRL_EN_BIT];
      cmp1_pos_hyst_sel_q <= CMP1_CTRL_RST[CTRL_HYP_LSB +: FIELD_W];
      cmp1_neg_hyst_sel_q <= CMP1_CTRL_RST[CTRL_HYN_LSB +: FIELD_W];
    end else if (wr_ctrl) begin
      cmp1_enable_q       <= i_sfr_wdata[CTRL_EN_BIT];
      cmp1_pos_hyst_sel_q <= i_sfr_wdata[CTRL_HYP_LSB +: FIELD_W];
      cmp1_neg_hyst_sel_q <= i_sfr_wdata[CTRL_HYN_LSB +: FIELD_W];
    end
  end

  // edge flags: an edge in the cycle of a clearing write still sets
  always_comb begin
    cmp1_rise_flag_d = cmp1_rise_flag_q;
    cmp1_fall_flag_d = cmp1_fall_flag_q;
    if (wr_ctrl) begin
      cmp1_rise_flag_d = i_sfr_wdata[CTRL_RISE_BIT];
      cmp1_fall_flag_d = i_sfr_wdata[CTRL_FALL_BIT];
    end
    if (cmp1_rise) begin
      cmp1_rise_flag_d = 1'b1;
    end
    if (cmp1_fall) begin
      cmp1_fall_flag_d = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmp1_rise_flag_q <= CMP1_CTRL_RST[CTRL_RISE_BIT];
      cmp1_fall_flag_q <= CMP1_CTRL_RST[CTRL_FALL_BIT];
    end else begin
      cmp1_rise_flag_q <= cmp1_rise_flag_d;
      cmp1_fall_flag_q <= cmp1_fall_flag_d;
    end
  end

  // comparator1 input mux register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmp1_neg_input_sel_q <= CMP1_MUX_RST[MUX_NEG_LSB +: FIELD_W];
      cmp1_pos_input_sel_q <= CMP1_MUX_RST[MUX_POS_LSB +: FIELD_W];
    end else if (wr_mux) begin
      cmp1_neg_input_sel_q <= i_sfr_wdata[MUX_NEG_LSB +: FIELD_W];
      cmp1_pos_input_sel_q <= i_sfr_wdata[MUX_POS_LSB +: FIELD_W];
    end
  end

  // read image; unused bit positions are constant zero
  always_comb begin
    rdata_d = UNMAPPED_RD;
    unique case (i_sfr_addr)
      CMP1_CTRL_ADDR: begin
        rdata_d[CTRL_EN_BIT]   = cmp1_enable_q;
        rdata_d[CTRL_OUT_BIT]  = cmp1_result;
        rdata_d[CTRL_RISE_BIT] = cmp1_rise_flag_q;
        rdata_d[CTRL_FALL_BIT] = cmp1_fall_flag_q;
        rdata_d[CTRL_HYP_LSB +: FIELD_W] = cmp1_pos_hyst_sel_q;
        rdata_d[CTRL_HYN_LSB +: FIELD_W] = cmp1_neg_hyst_sel_q;
      end
      CMP1_MODE_ADDR: begin
        rdata_d = mode_image(cmp1_rise_irq_en_q, cmp1_fall_irq_en_q,
                             cmp1_response_sel_q);
      end
      CMP0_MODE_ADDR: begin
        rdata_d = mode_image(cmp0_rise_irq_en_q, cmp0_fall_irq_en_q,
                             cmp0_response_sel_q);
      end
      CMP1_MUX_ADDR: begin
        rdata_d[MUX_NEG_LSB +: FIELD_W] = cmp1_neg_input_sel_q;
        rdata_d[MUX_POS_LSB +: FIELD_W] = cmp1_pos_input_sel_q;
      end
      default: begin
        rdata_d = UNMAPPED_RD;
      end
    endcase
  end

  // read data is registered so the port comes from a flop; holds between
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sfr_rdata <= RDATA_RST;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rdata_d;
    end
  end

  // analog-side settings, registered copies of the fields
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cmp0_response <= resp_e'(CMP0_MODE_RST[MODE_RESP_LSB +: FIELD_W]);
      o_cmp1_cfg      <= CMP1_CFG_RST;
    end else begin
      o_cmp0_response      <= cmp0_response_sel_q;
      o_cmp1_cfg.enable    <= cmp1_enable_q;
      o_cmp1_cfg.response  <= cmp1_response_sel_q;
      o_cmp1_cfg.pos_hyst  <= cmp1_pos_hyst_sel_q;
      o_cmp1_cfg.neg_hyst  <= cmp1_neg_hyst_sel_q;
      o_cmp1_cfg.pos_input <= cmp1_pos_input_sel_q;
      o_cmp1_cfg.neg_input <= cmp1_neg_input_sel_q;
    end
  end

  // pin output forced low while disabled, so a stale result never leaks
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cmp1_pin_out <= 1'b0;
    end else begin
      o_cmp1_pin_out <= cmp1_result & cmp1_enable_q;
    end
  end

  // level interrupts; cmp0 flags live in its control register elsewhere
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cmp0_irq <= 1'b0;
      o_cmp1_irq <= 1'b0;
    end else begin
      o_cmp0_irq <= (i_cmp0_rise_flag & cmp0_rise_irq_en_q) |
                    (i_cmp0_fall_flag & cmp0_fall_irq_en_q);
      o_cmp1_irq <= (cmp1_rise_flag_q & cmp1_rise_irq_en_q) |
                    (cmp1_fall_flag_q & cmp1_fall_irq_en_q);
    end
  end

  // ---- checks ----
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_raw_rise;
    !i_cmp1_raw ##1 i_cmp1_raw [*3];
  endsequence

  sequence s_raw_fall;
    i_cmp1_raw ##1 !i_cmp1_raw [*3];
  endsequence

  rise_flag_set_a: assert property (
    s_raw_rise |-> ##1 cmp1_rise_flag_q)
    else $error("rising edge did not set the rise flag");

  fall_flag_set_a: assert property (
    s_raw_fall |-> ##1 cmp1_fall_flag_q)
    else $error("falling edge did not set the fall flag");

  flag_holds_a: assert property (
    cmp1_rise_flag_q && !wr_ctrl |=> cmp1_rise_flag_q)
    else $error("rise flag cleared without a write");

  set_beats_clear_a: assert property (
    wr_ctrl && !i_sfr_wdata[CTRL_FALL_BIT] && cmp1_fall
    |=> cmp1_fall_flag_q)
    else $error("fall edge lost under a clearing write");

  pin_low_off_a: assert property (
    !cmp1_enable_q |=> !o_cmp1_pin_out)
    else $error("pin output high while comparator disabled");

  unused_zero_a: assert property (
    i_sfr_rd && (i_sfr_addr == CMP1_MUX_ADDR)
    |=> (o_sfr_rdata & 8'hcc) == 8'h00)
    else $error("unused mux bits read nonzero");

  result_read_a: assert property (
    i_sfr_rd && (i_sfr_addr == CMP1_CTRL_ADDR)
    |=> o_sfr_rdata[CTRL_OUT_BIT] == $past(cmp1_result))
    else $error("result bit does not follow the synchronised output");

  enable_write_a: assert property (
    wr_ctrl |=> ##1 o_cmp1_cfg.enable == $past(i_sfr_wdata[CTRL_EN_BIT], 2))
    else $error("enable output does not follow the written bit");

  irq1_level_a: assert property (
    cmp1_rise_flag_q && cmp1_rise_irq_en_q |=> o_cmp1_irq)
    else $error("cmp1 interrupt missing with flag and enable set");

  irq0_gate_a: assert property (
    !cmp0_rise_irq_en_q && !cmp0_fall_irq_en_q |=> !o_cmp0_irq)
    else $error("cmp0 interrupt raised with both enables off");

  resp0_drive_a: assert property (
    wr_mode0 |=> ##1
      o_cmp0_response == $past(i_sfr_wdata[MODE_RESP_LSB +: FIELD_W], 2))
    else $error("cmp0 response code not driven to the core");

  resp1_drive_a: assert property (
    wr_mode1 |=> ##1
      o_cmp1_cfg.response == $past(i_sfr_wdata[MODE_RESP_LSB +: FIELD_W], 2))
    else $error("cmp1 response code not driven to the core");

endmodule // cmp_ctrl_regs

// ### common/cmp_regs_pkg.sv
// shared constants and types for the comparator control registers
package cmp_regs_pkg;

  // register addresses in the special-function-register space
  localparam logic [7:0] CMP1_CTRL_ADDR = 8'h9a;
  localparam logic [7:0] CMP1_MODE_ADDR = 8'h9c;
  localparam logic [7:0] CMP0_MODE_ADDR = 8'h9d;
  localparam logic [7:0] CMP1_MUX_ADDR  = 8'h9e;

  // reset values
  localparam logic [7:0] CMP1_CTRL_RST = 8'h00;
  localparam logic [7:0] CMP1_MODE_RST = 8'h02;
  localparam logic [7:0] CMP0_MODE_RST = 8'h02;
  localparam logic [7:0] CMP1_MUX_RST  = 8'h00;
  localparam logic [7:0] RDATA_RST     = 8'h00;
  localparam logic [7:0] UNMAPPED_RD   = 8'h00;

  // control register fields
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_OUT_BIT  = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_HYP_LSB  = 2;
  localparam int CTRL_HYN_LSB  = 0;

  // mode register fields
  localparam int MODE_RIE_BIT  = 5;
  localparam int MODE_FIE_BIT  = 4;
  localparam int MODE_RESP_LSB = 0;

  // mux register fields
  localparam int MUX_NEG_LSB = 4;
  localparam int MUX_POS_LSB = 0;

  localparam int FIELD_W = 2;

  // typical response times per code, in ns
  localparam int RESP_MODE0_NS = 100;
  localparam int RESP_MODE1_NS = 175;
  localparam int RESP_MODE2_NS = 320;
  localparam int RESP_MODE3_NS = 1050;

  typedef logic [FIELD_W-1:0] field_t;

  // response-time codes, fastest to slowest
  typedef enum logic [FIELD_W-1:0] {
    RESP_FAST,
    RESP_MID_FAST,
    RESP_MID_SLOW,
    RESP_SLOW
  } resp_e;

  // settings handed to the comparator1 analog core
  typedef struct packed {
    logic   enable;
    resp_e  response;
    field_t pos_hyst;
    field_t neg_hyst;
    field_t pos_input;
    field_t neg_input;
  } cmp_cfg_s;

  localparam cmp_cfg_s CMP1_CFG_RST = '{
    enable:    1'b0,
    response:  RESP_MID_SLOW,
    pos_hyst:  2'h0,
    neg_hyst:  2'h0,
    pos_input: 2'h0,
    neg_input: 2'h0
  };

endpackage

// ### src/cmp_sync.sv
// two-stage synchroniser for a raw comparator output, with edge pulses
`timescale 1ns/1ns
module cmp_sync (
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  input  wire logic i_raw,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // first stage feeds only the second; edges come from later stages
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q; // one-cycle pulse
  assign o_fall  = ~sync_q & prev_q; // one-cycle pulse

endmodule // cmp_sync

// ### test/cmp1_analog_model.sv
// behavioural model of the comparator1 analog core; its input mux is not modelled
`timescale 1ns/1ns
module cmp1_analog_model (
  input  wire cmp_regs_pkg::cmp_cfg_s i_cfg,
  input  wire logic                   i_pos_above,
  output logic                        o_raw
);
  import cmp_regs_pkg::*;
  int   delay_ns;
  logic target;

  // settle time follows the response code; hysteresis is not modelled
  always_comb begin
    case (i_cfg.response)
      RESP_FAST:     delay_ns = RESP_MODE0_NS;
      RESP_MID_FAST: delay_ns = RESP_MODE1_NS;
      RESP_MID_SLOW: delay_ns = RESP_MODE2_NS;
      default:       delay_ns = RESP_MODE3_NS;
    endcase
  end

  // a disabled core sits low; input codes are not decoded at all, so
  // every mux setting compares the same i_pos_above input
  assign target = i_cfg.enable & i_pos_above;

  initial o_raw = 1'b0;
  // transport delay keeps every level change, however short
  always @(target) o_raw <= #(delay_ns) target;
endmodule // cmp1_analog_model

// ### test/tb_top.sv
// self-checking bench for the comparator control registers
`timescale 1ns/1ns
module tb_top;
  import cmp_regs_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rd;
  } row_s;

  logic       core_clk;
  logic       rst_b;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       cmp1_raw;
  logic       cmp0_rise_flag;
  logic       cmp0_fall_flag;
  resp_e      cmp0_response;
  logic       cmp0_irq;
  cmp_cfg_s   cmp1_cfg;
  logic       cmp1_pin_out;
  logic       cmp1_irq;
  logic       pos_above;
  int         mismatches;
  int         total_checks;
  logic [7:0] sh_ctrl, sh_m1, sh_m0, sh_mux;
  row_s       rows [10];

  cmp_ctrl_regs uut (
    .i_core_clk       (core_clk),
    .i_rst_b          (rst_b),
    .i_sfr_addr       (sfr_addr),
    .i_sfr_wr         (sfr_wr),
    .i_sfr_rd         (sfr_rd),
    .i_sfr_wdata      (sfr_wdata),
    .o_sfr_rdata      (sfr_rdata),
    .i_cmp1_raw       (cmp1_raw),
    .i_cmp0_rise_flag (cmp0_rise_flag),
    .i_cmp0_fall_flag (cmp0_fall_flag),
    .o_cmp0_response  (cmp0_response),
    .o_cmp0_irq       (cmp0_irq),
    .o_cmp1_cfg       (cmp1_cfg),
    .o_cmp1_pin_out   (cmp1_pin_out),
    .o_cmp1_irq       (cmp1_irq)
  );

  cmp1_analog_model core (
    .i_cfg       (cmp1_cfg),
    .i_pos_above (pos_above),
    .o_raw       (cmp1_raw)
  );

  // free-running 100 MHz clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one write strobe, released one edge later
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge core_clk) #1;
    sfr_wr    = 1'b0;
  endtask

  // read data lands on the edge that takes the strobe
  task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk) #1;
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(posedge core_clk) #1;
    sfr_rd   = 1'b0;
    check(sfr_rdata, exp);
  endtask

  function automatic logic sig(input int sel);
    return (sel == 0) ? cmp1_irq : (sel == 1) ? cmp0_irq : cmp1_pin_out;
  endfunction

  // bounded wait; slowest response is about 105 cycles plus sync
  task automatic wait_for(input int sel, input logic want);
    repeat (300) begin
      if (sig(sel) === want) break;
      @(posedge core_clk) #1;
    end
    check(sig(sel), want);
  endtask

  function automatic logic [10:0] exp_cfg();
    return {sh_ctrl[7], sh_m1[1:0], sh_ctrl[3:0], sh_mux[1:0], sh_mux[5:4]};
  endfunction

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #50000;
    mismatches++;
    end_of_test();
  end

  initial begin
    rst_b = 1'b0; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0;
    sfr_wdata = 8'h00; cmp0_rise_flag = 1'b0; cmp0_fall_flag = 1'b0;
    pos_above = 1'b0; mismatches = 0; total_checks = 0;
    sh_ctrl = CMP1_CTRL_RST; sh_m1 = CMP1_MODE_RST;
    sh_m0 = CMP0_MODE_RST; sh_mux = CMP1_MUX_RST;
    rows = '{'{CMP0_MODE_ADDR, 8'hff, 8'h33},
             '{CMP0_MODE_ADDR, 8'h01, 8'h01},
             '{CMP0_MODE_ADDR, 8'h22, 8'h22},
             '{CMP1_MODE_ADDR, 8'hff, 8'h33},
             '{CMP1_MODE_ADDR, 8'h00, 8'h00},
             '{CMP1_MUX_ADDR,  8'hff, 8'h33},
             '{CMP1_MUX_ADDR,  8'h12, 8'h12},
             '{CMP1_CTRL_ADDR, 8'h4e, 8'h0e},
             '{CMP1_CTRL_ADDR, 8'h83, 8'h83},
             '{8'h55,          8'hff, 8'h00}};
    repeat (8) @(posedge core_clk);
    #1 rst_b = 1'b1;
    // reset state at the ports and in every register
    check(cmp1_cfg, CMP1_CFG_RST);
    check(cmp0_response, RESP_MID_SLOW);
    check({cmp0_irq, cmp1_irq, cmp1_pin_out, sfr_rdata}, 11'h000);
    read_chk(CMP1_CTRL_ADDR, CMP1_CTRL_RST);
    read_chk(CMP1_MODE_ADDR, CMP1_MODE_RST);
    read_chk(CMP0_MODE_ADDR, CMP0_MODE_RST);
    read_chk(CMP1_MUX_ADDR, CMP1_MUX_RST);
    // table: write, read back, and the settings handed to the cores
    foreach (rows[i]) begin
      sfr_write(rows[i].addr, rows[i].wdata);
      read_chk(rows[i].addr, rows[i].rd);
      case (rows[i].addr)
        CMP1_CTRL_ADDR: sh_ctrl = rows[i].rd;
        CMP1_MODE_ADDR: sh_m1 = rows[i].rd;
        CMP0_MODE_ADDR: sh_m0 = rows[i].rd;
        CMP1_MUX_ADDR:  sh_mux = rows[i].rd;
        default:        sh_m0 = sh_m0;
      endcase
      check(cmp1_cfg, exp_cfg());
      check(cmp0_response, sh_m0[1:0]);
    end
    // rising edge with its interrupt enabled
    sfr_write(CMP1_CTRL_ADDR, 8'h80);
    sfr_write(CMP1_MODE_ADDR, 8'h22);
    pos_above = 1'b1;
    wait_for(0, 1'b1);
    check(cmp1_pin_out, 1'b1);
    read_chk(CMP1_CTRL_ADDR, 8'he0);
    // swap enables: set rise flag alone no longer interrupts
    sfr_write(CMP1_MODE_ADDR, 8'h11);
    wait_for(0, 1'b0);
    check(cmp1_cfg.response, RESP_MID_FAST);
    sfr_write(CMP1_CTRL_ADDR, 8'h80);
    read_chk(CMP1_CTRL_ADDR, 8'hc0);
    // falling edge with its interrupt enabled, meeting a clearing write in the same cycle
    pos_above = 1'b0;
    repeat (300) begin
      @(posedge core_clk) #1;
      if (uut.cmp1_fall) break;
    end
    sfr_addr  = CMP1_CTRL_ADDR;
    sfr_wdata = 8'h80;
    sfr_wr    = 1'b1;
    @(posedge core_clk) #1;
    sfr_wr    = 1'b0;
    wait_for(0, 1'b1);
    read_chk(CMP1_CTRL_ADDR, 8'h90);
    sfr_write(CMP1_CTRL_ADDR, 8'h80);
    wait_for(0, 1'b0);
    // disabling forces the pin low before the core output falls
    pos_above = 1'b1;
    wait_for(2, 1'b1);
    sfr_write(CMP1_CTRL_ADDR, 8'h00);
    @(posedge core_clk) #1;
    check(cmp1_pin_out, 1'b0);
    // comparator0 interrupt gating, enables 0x22 then 0x10
    cmp0_rise_flag = 1'b1;
    wait_for(1, 1'b1);
    cmp0_rise_flag = 1'b0;
    cmp0_fall_flag = 1'b1;
    wait_for(1, 1'b0);
    sfr_write(CMP0_MODE_ADDR, 8'h10);
    wait_for(1, 1'b1);
    check(cmp0_response, RESP_FAST);
    // mid-run reset, core output settled low first so no edge follows
    pos_above = 1'b0;
    repeat (110) @(posedge core_clk);
    #1 rst_b = 1'b0;
    @(posedge core_clk) #1;
    rst_b = 1'b1;
    check({cmp0_irq, cmp1_irq, cmp1_pin_out, sfr_rdata}, 11'h000);
    check(cmp1_cfg, CMP1_CFG_RST);
    check(cmp0_response, RESP_MID_SLOW);
    read_chk(CMP1_CTRL_ADDR, CMP1_CTRL_RST);
    read_chk(CMP0_MODE_ADDR, CMP0_MODE_RST);
    end_of_test();
  end
endmodule // tb_top
